/* File: inc/crs_regs.svh */
// constants for the character pattern overlay and video address decode
// assumes a 16-bit processor address space and a 14-bit video address per bank
// Functional notes
// - i/o registers and pattern memory share one 4K range; only one answers
// - configuration bit 0 set selects pattern memory, clear selects i/o registers
// - after power-up the shared range addresses the i/o registers
// - processor writes never change pattern memory contents
// - video fetches come from one 16K bank at a time
// - absolute character start equals in-bank base plus 16384 times bank number
// - low nibble of video pointer selects character base, high nibble kept
// - field 8 gives 8192, 12 gives 12288, 14 gives 14336 in bank 0
// - each pattern is eight bytes, one per row; a 1 bit is foreground
// - compatibility mode: port bit 2 clear swaps in pattern memory
`ifndef CRS_REGS_SVH
`define CRS_REGS_SVH
// ==========================================
// address map
`define CRS_SHARED_BASE 16'hd000
`define CRS_SHARED_TOP 16'hdfff
`define CRS_CFG_ADDR 16'hff00
`define CRS_PORT_ADDR 16'h0001
// ==========================================
// field positions and reset values
`define CRS_CFG_SEL_BIT 0
`define CRS_PORT_IO_BIT 2
`define CRS_CFG_RST 8'h00
`define CRS_PORT_RST 8'h07
`define CRS_VPTR_RST 8'h14
`define CRS_BANK_BYTES 17'h04000
`define CRS_CHAR_UNIT 14'h0400
`define CRS_ROWS 3'h7
`endif

/* File: inc/crs_pkg.sv */
// types for the character pattern overlay block
// assumes crs_regs.svh is included by the design files
package crs_pkg;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic valid;
  } crs_req_s;
  typedef struct packed {
    logic io_sel;
    logic pat_sel;
    logic ram_sel;
  } crs_sel_s;
  typedef enum logic [1:0] {
    CRS_MAP_IO = 2'b00,
    CRS_MAP_PAT = 2'b01,
    CRS_MAP_RAM = 2'b10
  } crs_map_e;
endpackage : crs_pkg

/* File: hw/crs_overlay.sv */
// decode, overlay selection and video character address for one processor
// assumes single-cycle processor requests on clk_i and a pattern memory read port
`timescale 1ns/1ns
`include "crs_regs.svh"
module crs_overlay #(
  parameter int PAT_AW = 12
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic compat_i,
  input wire crs_pkg::crs_req_s req_i,
  input wire logic [7:0] vptr_wdata_i,
  input wire logic [3:0] vptr_base_wdata_i,
  input wire logic vptr_wr_i,
  input wire logic vptr_base_wr_i,
  input wire logic [1:0] vbank_i,
  input wire logic [7:0] screen_code_i,
  input wire logic [2:0] row_i,
  output logic [7:0] cfg_o,
  output logic [7:0] port_o,
  output logic [7:0] vptr_o,
  output crs_pkg::crs_sel_s sel_o,
  output logic pat_wr_block_o,
  output logic [PAT_AW-1:0] pat_addr_o,
  output logic [13:0] char_base_o,
  output logic [16:0] char_abs_o,
  output logic [15:0] video_addr_o,
  output logic [1:0] video_bank_o
);
  import crs_pkg::*;

  initial
  begin
    if (PAT_AW != 12)
      $error("pattern memory must be 4K");
  end

  // ==========================================
  // configuration state
  logic [7:0] cfg;
  logic [7:0] port;
  logic [7:0] vptr;
  logic [1:0] vbank;
  logic [1:0] vbank_m;
  logic compat_m;
  logic compat;

  wire logic cfg_hit = req_i.valid && req_i.wr && req_i.addr == `CRS_CFG_ADDR;
  wire logic port_hit = req_i.valid && req_i.wr && req_i.addr == `CRS_PORT_ADDR;
  wire logic [7:0] next_vptr = vptr_wr_i ? vptr_wdata_i :
    vptr_base_wr_i ? {vptr[7:4], vptr_base_wdata_i} : vptr;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cfg <= `CRS_CFG_RST;
      port <= `CRS_PORT_RST;
      vptr <= `CRS_VPTR_RST;
      vbank_m <= 2'h0;
      vbank <= 2'h0;
      compat_m <= 1'b0;
      compat <= 1'b0;
    end
    else
    begin
      if (cfg_hit)
        cfg <= req_i.wdata;
      if (port_hit)
        port <= req_i.wdata;
      vptr <= next_vptr;
      vbank_m <= vbank_i;
      vbank <= vbank_m;
      compat_m <= compat_i;
      compat <= compat_m;
    end
  end

  // ==========================================
  // shared range decode: exactly one of io or pattern memory answers
  wire logic in_shared = req_i.valid && req_i.addr >= `CRS_SHARED_BASE
    && req_i.addr <= `CRS_SHARED_TOP;
  // host must halt its interrupt timer before swapping; no timer is gated here
  wire logic pat_mode = compat ? !port[`CRS_PORT_IO_BIT] : cfg[`CRS_CFG_SEL_BIT];
  wire logic pat_sel = in_shared && pat_mode;
  wire logic io_sel = in_shared && !pat_mode;

  assign sel_o.pat_sel = pat_sel;
  assign sel_o.io_sel = io_sel;
  // writes into a pattern-mapped window are blocked by pat_wr_block_o; ram is selected only outside the shared range
  assign sel_o.ram_sel = req_i.valid && !in_shared;
  assign pat_wr_block_o = pat_sel && req_i.wr;
  assign pat_addr_o = req_i.addr[PAT_AW-1:0];
  assign cfg_o = cfg;
  assign port_o = port;
  assign vptr_o = vptr;

  // ==========================================
  // video side character addressing
  // field bit 0 is ignored so the base stays on a 2K boundary
  wire logic [13:0] char_base = 14'({vptr[3:1], 1'b0}) * `CRS_CHAR_UNIT;
  assign char_base_o = char_base;
  assign char_abs_o = 17'(char_base) + 17'(vbank) * `CRS_BANK_BYTES;
  assign video_bank_o = vbank;
  // eight bytes per pattern, row selects the byte
  assign video_addr_o = {vbank, char_base + {3'h0, screen_code_i, row_i}};

  // ==========================================
  // checks
  AST_ONE_SEL: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !(sel_o.pat_sel && sel_o.io_sel)) else $error("both io and pattern selected");
  AST_CFG_SEL: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!compat && in_shared && cfg[0]) |-> sel_o.pat_sel) else $error("cfg bit0 ignored");
  AST_CFG_IO: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!compat && in_shared && !cfg[0]) |-> sel_o.io_sel) else $error("io not selected");
  AST_NO_ROM_WR: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (sel_o.pat_sel && req_i.wr) |-> pat_wr_block_o) else $error("rom write open");
  AST_BANK: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    video_addr_o[15:14] == video_bank_o) else $error("fetch left bank");
  AST_ABS: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    char_abs_o == 17'(char_base_o) + 17'(video_bank_o) * 17'h04000) else $error("abs wrong");
  AST_KEEP_HI: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (vptr_base_wr_i && !vptr_wr_i) |=> vptr_o[7:4] == $past(vptr_o[7:4])) else $error("hi lost");
  AST_BASE12: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    vptr_o[3:0] == 4'hc |-> char_base_o == 14'h3000) else $error("base 12 wrong");
  AST_COMPAT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (compat && in_shared && !port_o[2]) |-> sel_o.pat_sel) else $error("port swap failed");
  AST_ALIGN: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    char_base_o[10:0] == 11'h000) else $error("base not 2K aligned");
  AST_BASE8: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    vptr_o[3:0] == 4'h8 |-> char_base_o == 14'h2000) else $error("base 8 wrong");
  AST_BASE14: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    vptr_o[3:0] == 4'he |-> char_base_o == 14'h3800) else $error("base 14 wrong");
  // a full pointer write overrides a same-cycle base write
  AST_FULL_WR: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    vptr_wr_i |=> vptr_o == $past(vptr_wdata_i)) else $error("full write lost");
  AST_COMPAT_IO: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (compat && in_shared && port_o[2]) |-> sel_o.io_sel) else $error("io not restored");
  AST_ROW: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    video_addr_o[2:0] == row_i) else $error("row byte wrong");
endmodule : crs_overlay

/* File: tb/crs_host.sv */
// host core model: one processor access per call
// assumes calls come just after a rising edge of the clock
`timescale 1ns/1ns
module crs_host (
  output crs_pkg::crs_req_s req_o
);
  import crs_pkg::*;
  // ==========================
  // access tasks
  task acc(input logic [15:0] a, input logic [7:0] d, input logic w);
    req_o = '{a, d, w, 1'b1};
  endtask : acc
  // a released bus shows inverted values, never the last ones
  task idle();
    req_o = '{~req_o.addr, ~req_o.wdata, 1'b0, 1'b0};
  endtask : idle
  initial req_o = '0;
endmodule : crs_host

/* File: tb/crs_overlay_test.sv */
// bench comparing the overlay decode with an integer model
// assumes crs_host drives the processor request
`timescale 1ns/1ns
`include "crs_regs.svh"
module crs_overlay_test;
  import crs_pkg::*;
  logic clk_i, rst_b_i, compat_i, vptr_wr_i, vptr_base_wr_i, blk;
  logic [7:0] vptr_wdata_i, screen_code_i, cfg_o, port_o, vptr_o;
  logic [3:0] vptr_base_wdata_i;
  logic [1:0] vbank_i, video_bank_o;
  logic [2:0] row_i;
  logic [11:0] pa;
  logic [13:0] cb;
  logic [16:0] ca;
  logic [15:0] va;
  logic [31:0] rnd = 32'hf66c;
  crs_req_s req;
  crs_sel_s sel_o;
  int err_total, n_tests, m_cfg, m_port;
  int fv[3] = '{8, 12, 14};
  int bv[3] = '{8192, 12288, 14336};
  crs_host host (.req_o(req));
  crs_overlay DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .compat_i(compat_i), .req_i(req),
    .vptr_wdata_i(vptr_wdata_i), .vptr_base_wdata_i(vptr_base_wdata_i),
    .vptr_wr_i(vptr_wr_i), .vptr_base_wr_i(vptr_base_wr_i), .vbank_i(vbank_i),
    .screen_code_i(screen_code_i), .row_i(row_i), .cfg_o(cfg_o), .port_o(port_o),
    .vptr_o(vptr_o), .sel_o(sel_o), .pat_wr_block_o(blk), .pat_addr_o(pa),
    .char_base_o(cb), .char_abs_o(ca), .video_addr_o(va), .video_bank_o(video_bank_o));
  // ==========================
  // helpers
  function logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      err_total++;
      $display("Error at %0t: seen %0h expected %0h", $time, s, e);
    end
  endtask : chk
  task test_done();
    $display("compares %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  // one access; the model reads compat_i unsynced, so callers let the synced mode in the DUT settle
  task cyc(input logic [15:0] a, input logic [7:0] d, input logic w);
    logic p, in;
    @(posedge clk_i);
    #1 host.acc(a, d, w);
    #1 p = compat_i ? !m_port[2] : m_cfg[0];
    in = a[15:12] == 4'hd;
    chk(sel_o, {in & !p, in & p, !in});
    chk(blk, w & in & p);
    chk(pa, a[11:0]);
    if (w && a == `CRS_CFG_ADDR) m_cfg = d;
    if (w && a == `CRS_PORT_ADDR) m_port = d;
  endtask : cyc
  // ==========================
  // stimulus
  initial
  begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end
  // generous span: the tests need well under a microsecond
  initial
  begin
    #50000 err_total++;
    test_done();
  end
  initial
  begin
    {compat_i, vptr_wr_i, vptr_base_wr_i, vptr_wdata_i, vptr_base_wdata_i} = '0;
    {vbank_i, screen_code_i, row_i, m_cfg, m_port, rst_b_i} = {13'h0, 32'h0, 32'h7, 1'b0};
    repeat (16) @(posedge clk_i);
    #1 rst_b_i = 1;
    chk({cfg_o, port_o, vptr_o}, 24'h000714);
    cyc(16'hd000, 8'h00, 0);
    cyc(`CRS_CFG_ADDR, 8'h01, 1);
    cyc(16'hdfff, 8'h00, 0);
    cyc(16'hd123, 8'h5a, 1);
    cyc(16'he000, 8'h00, 0);
    chk(cfg_o, 8'h01);
    @(posedge clk_i);
    #1 compat_i = 1;
    repeat (3) @(posedge clk_i);
    for (int v = 0; v < 2; v++)
    begin
      cyc(`CRS_PORT_ADDR, v ? 8'h07 : 8'h03, 1);
      cyc(16'hd800, 8'h00, 0);
    end
    host.idle();
    $display("test decode done");
    @(posedge clk_i);
    #1 {vptr_wdata_i, vptr_wr_i} = {8'h50, 1'b1};
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk_i);
      #1 {vptr_wr_i, vptr_base_wdata_i, vptr_base_wr_i} = {1'b0, fv[i][3:0], 1'b1};
      @(posedge clk_i);
      #1 vptr_base_wr_i = 0;
      chk(vptr_o, 8'h50 | fv[i]);
      chk(cb, bv[i]);
    end
    for (int b = 0; b < 4; b++)
    begin
      rnd = lfsr(rnd);
      {vbank_i, screen_code_i, row_i} = {b[1:0], rnd[10:0]};
      repeat (3) @(posedge clk_i);
      #1 chk(video_bank_o, b);
      chk(ca, 14336 + 16384 * b);
      chk(va, 16384 * b + 14336 + rnd[10:0]);
    end
    $display("test video done");
    test_done();
  end
endmodule : crs_overlay_test
